// *** design/psq_sequencer.v ***
// Slot-based power sequencer with its byte configuration registers
// How it works
// - Position register low nibble reads current slot; upper nibble is reserved storage.
// - Normal slot time comes from a 4-bit code via the sixteen-entry table.
// - Empty slots dwell using the upper timing nibble, same duration table.
// - Each linear regulator switches at the slot held in its own nibble.
// - Each switcher switches at its own slot nibble; two per byte.
// - Pull-down-disable applies at the slot in the upper nibble of its byte.
// - Each general output asserts at its low-nibble slot, releases at its high-nibble slot.
// - Output and calendar clocks enable at the slot in the clock byte's upper nibble.
// - Wait function runs at the slot in the clock byte's lower nibble.
// - Upper nibble of first boundary byte marks end of the main domain.
// - Lower nibble of first boundary byte marks end of the system domain.
// - Standby power-down stops at upper nibble of second boundary byte, at least one.
// - Lower nibble of second boundary byte is the highest slot used.
// - Wait step holds for the pause input, or for the external wait timer.
// - Direction field selects waiting on power-up, power-down, both or neither.
`timescale 1ns/1ps
`include "psq_map.vh"
module psq_sequencer #(
  parameter TICK_CYCLES = `PSQ_BASE_NS / `PSQ_CLK_NS,
  parameter N_LIN       = 4,
  parameter N_SW        = 4,
  parameter N_OUT       = 5
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [7:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [7:0]       reg_rdata_r,
  input  wire             power_up_req,
  input  wire             power_down_req,
  input  wire             standby_req,
  input  wire [1:0]       wait_dir,
  input  wire             wait_mode,
  input  wire             ext_pause_input,
  input  wire             wait_timer_done,
  output reg              wait_timer_start_r,
  output reg  [N_LIN-1:0] linreg_en_r,
  output reg  [N_SW-1:0]  switcher_en_r,
  output reg  [N_OUT-1:0] gen_out_r,
  output reg              pulldown_off_r,
  output reg              out_clk_en_r,
  output reg              cal_clk_en_r,
  output reg              system_domain_up_r,
  output reg              main_domain_up_r,
  output reg              busy_r
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_STEP = 4'b0010;
  localparam ST_SLOT = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  // Configuration bytes
  reg  [7:0] pos_hi_r;
  reg  [7:0] timing_r;
  reg  [7:0] lin_a_r;
  reg  [7:0] lin_b_r;
  reg  [7:0] pd_r;
  reg  [7:0] sw_a_r;
  reg  [7:0] sw_b_r;
  reg  [7:0] out_r [0:N_OUT-1];
  reg  [7:0] clkw_r;
  reg  [7:0] bnd_a_r;
  reg  [7:0] bnd_b_r;

  // Sequencer state
  reg  [3:0] state_r;
  reg  [3:0] pos_r;
  reg  [3:0] target_r;
  reg        dir_up_r;
  reg        tmr_start_r;
  reg  [3:0] tmr_code_r;
  reg        tmr_start_nxt;
  integer    i;
  integer    j;
  integer    k;

  wire       tmr_done;
  wire       pause_s;
  wire [3:0] lin_slot [0:N_LIN-1];
  wire [3:0] sw_slot  [0:N_SW-1];
  wire [3:0] slot_len;
  wire [3:0] empty_dwell;
  wire [3:0] pulldown_off_slot;
  wire [3:0] clock_enable_slot;
  wire [3:0] wait_slot;
  wire [3:0] main_end;
  wire [3:0] system_end;
  wire [3:0] standby_stop_slot;
  wire [3:0] max_slot;
  wire       slot_empty;
  wire       wait_here;
  wire       wait_ok;
  wire       slot_over;
  wire [3:0] pos_dn;

  // Field extraction
  assign slot_len          = timing_r[`PSQ_LO];
  assign empty_dwell       = timing_r[`PSQ_HI];
  assign lin_slot[0]       = lin_a_r[`PSQ_LO];
  assign lin_slot[1]       = lin_a_r[`PSQ_HI];
  assign lin_slot[2]       = lin_b_r[`PSQ_LO];
  assign lin_slot[3]       = lin_b_r[`PSQ_HI];
  assign sw_slot[0]        = sw_a_r[`PSQ_LO];
  assign sw_slot[1]        = sw_a_r[`PSQ_HI];
  assign sw_slot[2]        = sw_b_r[`PSQ_HI];
  assign sw_slot[3]        = sw_b_r[`PSQ_LO];
  assign pulldown_off_slot = pd_r[`PSQ_HI];
  assign clock_enable_slot = clkw_r[`PSQ_HI];
  assign wait_slot         = clkw_r[`PSQ_LO];
  assign main_end          = bnd_a_r[`PSQ_HI];
  assign system_end        = bnd_a_r[`PSQ_LO];
  assign standby_stop_slot = bnd_b_r[`PSQ_HI];
  assign max_slot          = bnd_b_r[`PSQ_LO];
  assign pos_dn            = pos_r - `PSQ_SLOT_ONE;

  // A slot is empty when no regulator or switcher sits on it
  reg empty_c;
  always @* begin
    empty_c = 1'b1;
    for (j = 0; j < N_LIN; j = j + 1) begin
      if (lin_slot[j] == pos_r) begin
        empty_c = 1'b0;
      end
    end
    for (j = 0; j < N_SW; j = j + 1) begin
      if (sw_slot[j] == pos_r) begin
        empty_c = 1'b0;
      end
    end
  end
  assign slot_empty = empty_c;

  // Wait decision at the end of the wait slot
  assign wait_here = (pos_r == wait_slot) &&
                     (dir_up_r ? wait_dir[`PSQ_WDIR_UP] : wait_dir[`PSQ_WDIR_DOWN]);
  assign wait_ok   = wait_mode ? wait_timer_done : pause_s;
  assign slot_over = (state_r == ST_SLOT && tmr_done && !wait_here) ||
                     (state_r == ST_WAIT && wait_ok);

  psq_sync3 u_pause_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .din    (ext_pause_input),
    .dout_r (pause_s)
  );

  psq_slot_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_slot_timer (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .start  (tmr_start_r),
    .code   (tmr_code_r),
    .done_r (tmr_done)
  );

  // Register writes; position nibble itself is read-only
  always @(posedge mclk) begin
    if (!rst_n) begin
      pos_hi_r <= `PSQ_CFG_RST;
      timing_r <= `PSQ_CFG_RST;
      lin_a_r  <= `PSQ_CFG_RST;
      lin_b_r  <= `PSQ_CFG_RST;
      pd_r     <= `PSQ_CFG_RST;
      sw_a_r   <= `PSQ_CFG_RST;
      sw_b_r   <= `PSQ_CFG_RST;
      clkw_r   <= `PSQ_CFG_RST;
      bnd_a_r  <= `PSQ_CFG_RST;
      bnd_b_r  <= `PSQ_CFG_RST;
      for (k = 0; k < N_OUT; k = k + 1) begin
        out_r[k] <= `PSQ_CFG_RST;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `PSQ_OFS_POSITION: pos_hi_r <= reg_wdata;
        `PSQ_OFS_TIMING:   timing_r <= reg_wdata;
        `PSQ_OFS_LINREG_A: lin_a_r  <= reg_wdata;
        `PSQ_OFS_LINREG_B: lin_b_r  <= reg_wdata;
        `PSQ_OFS_PULLDOWN: pd_r     <= reg_wdata;
        `PSQ_OFS_SWITCH_A: sw_a_r   <= reg_wdata;
        `PSQ_OFS_SWITCH_B: sw_b_r   <= reg_wdata;
        `PSQ_OFS_OUT0:     out_r[0] <= reg_wdata;
        `PSQ_OFS_OUT1:     out_r[1] <= reg_wdata;
        `PSQ_OFS_OUT2:     out_r[2] <= reg_wdata;
        `PSQ_OFS_OUT3:     out_r[3] <= reg_wdata;
        `PSQ_OFS_OUT4:     out_r[4] <= reg_wdata;
        `PSQ_OFS_CLKPAUSE: clkw_r   <= reg_wdata;
        `PSQ_OFS_BOUNDS_A: bnd_a_r  <= reg_wdata;
        `PSQ_OFS_BOUNDS_B: bnd_b_r  <= reg_wdata;
        default:           pos_hi_r <= pos_hi_r;
      endcase
    end
  end

  // Register reads, one cycle after the strobe; unmapped reads give zero
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_r <= `PSQ_CFG_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        `PSQ_OFS_POSITION: reg_rdata_r <= {pos_hi_r[`PSQ_HI], pos_r};
        `PSQ_OFS_TIMING:   reg_rdata_r <= timing_r;
        `PSQ_OFS_LINREG_A: reg_rdata_r <= lin_a_r;
        `PSQ_OFS_LINREG_B: reg_rdata_r <= lin_b_r;
        `PSQ_OFS_PULLDOWN: reg_rdata_r <= pd_r;
        `PSQ_OFS_SWITCH_A: reg_rdata_r <= sw_a_r;
        `PSQ_OFS_SWITCH_B: reg_rdata_r <= sw_b_r;
        `PSQ_OFS_OUT0:     reg_rdata_r <= out_r[0];
        `PSQ_OFS_OUT1:     reg_rdata_r <= out_r[1];
        `PSQ_OFS_OUT2:     reg_rdata_r <= out_r[2];
        `PSQ_OFS_OUT3:     reg_rdata_r <= out_r[3];
        `PSQ_OFS_OUT4:     reg_rdata_r <= out_r[4];
        `PSQ_OFS_CLKPAUSE: reg_rdata_r <= clkw_r;
        `PSQ_OFS_BOUNDS_A: reg_rdata_r <= bnd_a_r;
        `PSQ_OFS_BOUNDS_B: reg_rdata_r <= bnd_b_r;
        default:           reg_rdata_r <= `PSQ_CFG_RST;
      endcase
    end
  end

  // Timer start request for the step state
  always @* begin
    tmr_start_nxt = (state_r == ST_STEP);
  end

  // Slot walk: up one slot per period, down in reverse order
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_r            <= ST_IDLE;
      pos_r              <= `PSQ_SLOT_RST;
      target_r           <= `PSQ_SLOT_RST;
      dir_up_r           <= 1'b1;
      tmr_start_r        <= 1'b0;
      tmr_code_r         <= `PSQ_SLOT_RST;
      wait_timer_start_r <= 1'b0;
    end else begin
      tmr_start_r        <= tmr_start_nxt;
      wait_timer_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (power_up_req && pos_r < max_slot) begin
            dir_up_r <= 1'b1;
            target_r <= max_slot;
            pos_r    <= pos_r + `PSQ_SLOT_ONE;
            state_r  <= ST_STEP;
          end else if (standby_req && pos_r > standby_stop_slot &&
                       standby_stop_slot >= `PSQ_SLOT_ONE) begin
            dir_up_r <= 1'b0;
            target_r <= standby_stop_slot;
            state_r  <= ST_STEP;
          end else if (power_down_req && pos_r > `PSQ_SLOT_RST) begin
            dir_up_r <= 1'b0;
            target_r <= `PSQ_SLOT_RST;
            state_r  <= ST_STEP;
          end
        end
        ST_STEP: begin
          // Empty slots take the dwell code instead of the slot length
          tmr_code_r <= slot_empty ? empty_dwell : slot_len;
          state_r    <= ST_SLOT;
        end
        ST_SLOT: begin
          if (tmr_done && wait_here) begin
            wait_timer_start_r <= wait_mode;
            state_r            <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state_r <= state_r;
        end
        default: state_r <= ST_IDLE;
      endcase
      // Leave the slot: move on or stop at the target
      if (slot_over) begin
        if (dir_up_r) begin
          if (pos_r < target_r) begin
            pos_r   <= pos_r + `PSQ_SLOT_ONE;
            state_r <= ST_STEP;
          end else begin
            state_r <= ST_IDLE;
          end
        end else begin
          pos_r   <= pos_dn;
          state_r <= (pos_dn > target_r) ? ST_STEP : ST_IDLE;
        end
      end
    end
  end

  // Slot actions on entering a step; down direction undoes them
  always @(posedge mclk) begin
    if (!rst_n) begin
      linreg_en_r    <= {N_LIN{1'b0}};
      switcher_en_r  <= {N_SW{1'b0}};
      gen_out_r      <= {N_OUT{1'b0}};
      pulldown_off_r <= 1'b0;
      out_clk_en_r   <= 1'b0;
      cal_clk_en_r   <= 1'b0;
    end else if (state_r == ST_STEP) begin
      for (i = 0; i < N_LIN; i = i + 1) begin
        if (lin_slot[i] == pos_r) begin
          linreg_en_r[i] <= dir_up_r;
        end
      end
      for (i = 0; i < N_SW; i = i + 1) begin
        if (sw_slot[i] == pos_r) begin
          switcher_en_r[i] <= dir_up_r;
        end
      end
      for (i = 0; i < N_OUT; i = i + 1) begin
        if (out_r[i][`PSQ_LO] == pos_r) begin
          gen_out_r[i] <= dir_up_r;
        end else if (out_r[i][`PSQ_HI] == pos_r) begin
          gen_out_r[i] <= !dir_up_r;
        end
      end
      if (pulldown_off_slot == pos_r) begin
        pulldown_off_r <= dir_up_r;
      end
      if (clock_enable_slot == pos_r) begin
        out_clk_en_r <= dir_up_r;
        cal_clk_en_r <= dir_up_r;
      end
    end
  end

  // Domain status and busy flag
  always @(posedge mclk) begin
    if (!rst_n) begin
      system_domain_up_r <= 1'b0;
      main_domain_up_r   <= 1'b0;
      busy_r             <= 1'b0;
    end else begin
      system_domain_up_r <= (pos_r >= system_end);
      main_domain_up_r   <= (pos_r >= main_end);
      busy_r             <= (state_r != ST_IDLE);
    end
  end
endmodule

// *** design/psq_map.vh ***
// Register map, field positions, reset values and timing for the slot sequencer
`ifndef PSQ_MAP_VH
`define PSQ_MAP_VH

// Byte register offsets
`define PSQ_OFS_POSITION   8'h81
`define PSQ_OFS_TIMING     8'h82
`define PSQ_OFS_LINREG_A   8'h83
`define PSQ_OFS_LINREG_B   8'h84
`define PSQ_OFS_PULLDOWN   8'h88
`define PSQ_OFS_SWITCH_A   8'h89
`define PSQ_OFS_SWITCH_B   8'h8A
`define PSQ_OFS_OUT0       8'h8D
`define PSQ_OFS_OUT1       8'h8E
`define PSQ_OFS_OUT2       8'h8F
`define PSQ_OFS_OUT3       8'h90
`define PSQ_OFS_OUT4       8'h91
`define PSQ_OFS_CLKPAUSE   8'h92
`define PSQ_OFS_BOUNDS_A   8'h95
`define PSQ_OFS_BOUNDS_B   8'h96

// Nibble field positions
`define PSQ_LO             3:0
`define PSQ_HI             7:4
`define PSQ_WDIR_UP        0
`define PSQ_WDIR_DOWN      1

// Reset value of every configuration byte
`define PSQ_CFG_RST        8'h00
`define PSQ_SLOT_RST       4'h0
`define PSQ_SLOT_ONE       4'h1

// Slot duration table, in 32 us base units
`define PSQ_BASE_NS        32000
`define PSQ_CLK_NS         40
`define PSQ_DUR_LIN_MAX    4'h8
`define PSQ_DUR_384        9'h00C
`define PSQ_DUR_448        9'h00E
`define PSQ_DUR_512        9'h010
`define PSQ_DUR_1024       9'h020
`define PSQ_DUR_2048       9'h040
`define PSQ_DUR_4096       9'h080
`define PSQ_DUR_8192       9'h100
`define PSQ_DUR_ONE        9'h001

`endif

// *** design/psq_sync3.v ***
// Three-stage synchroniser that only reports a change once stages two and three agree
`timescale 1ns/1ps
module psq_sync3 (
  input  wire mclk,
  input  wire rst_n,
  input  wire din,
  output reg  dout_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Shift chain; output follows only a settled level
  always @(posedge mclk) begin
    if (!rst_n) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout_r <= s3_r;
      end
    end
  end
endmodule

// *** design/psq_slot_timer.v ***
// Slot timer: 32 us tick divider and sixteen-entry duration table
`timescale 1ns/1ps
`include "psq_map.vh"
module psq_slot_timer #(
  parameter TICK_CYCLES = `PSQ_BASE_NS / `PSQ_CLK_NS
) (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       start,
  input  wire [3:0] code,
  output reg        done_r
);
  reg  [9:0] div_r;
  reg  [8:0] cnt_r;
  reg        run_r;
  reg  [8:0] ticks;
  wire       tick;

  // Code to number of 32 us units
  always @* begin
    ticks = `PSQ_DUR_ONE;
    if (code <= `PSQ_DUR_LIN_MAX) begin
      ticks = {5'h00, code} + `PSQ_DUR_ONE;
    end else begin
      case (code)
        4'h9:    ticks = `PSQ_DUR_384;
        4'hA:    ticks = `PSQ_DUR_448;
        4'hB:    ticks = `PSQ_DUR_512;
        4'hC:    ticks = `PSQ_DUR_1024;
        4'hD:    ticks = `PSQ_DUR_2048;
        4'hE:    ticks = `PSQ_DUR_4096;
        default: ticks = `PSQ_DUR_8192;
      endcase
    end
  end

  assign tick = run_r && (div_r == TICK_CYCLES[9:0] - 10'h001);

  // Count base units; done pulses once at the end
  always @(posedge mclk) begin
    if (!rst_n) begin
      div_r  <= 10'h000;
      cnt_r  <= 9'h000;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        div_r <= 10'h000;
        cnt_r <= ticks;
        run_r <= 1'b1;
      end else if (run_r) begin
        div_r <= tick ? 10'h000 : div_r + 10'h001;
        if (tick) begin
          if (cnt_r == `PSQ_DUR_ONE) begin
            run_r  <= 1'b0;
            done_r <= 1'b1;
          end
          cnt_r <= cnt_r - `PSQ_DUR_ONE;
        end
      end
    end
  end
endmodule

// *** bench/psq_sequencer_properties.sv ***
// Port-level assertion checker for the slot sequencer
`timescale 1ns/1ps
module psq_sequencer_properties #(
  parameter TICK_CYCLES = 800,
  parameter N_LIN       = 4,
  parameter N_SW        = 4,
  parameter N_OUT       = 5
) (
  input wire             mclk,
  input wire             rst_n,
  input wire [7:0]       reg_addr,
  input wire             reg_rd,
  input wire [7:0]       reg_rdata_r,
  input wire [1:0]       wait_dir,
  input wire             wait_mode,
  input wire             wait_timer_start_r,
  input wire [N_LIN-1:0] linreg_en_r,
  input wire [N_SW-1:0]  switcher_en_r,
  input wire [N_OUT-1:0] gen_out_r,
  input wire             pulldown_off_r,
  input wire             out_clk_en_r,
  input wire             cal_clk_en_r,
  input wire             system_domain_up_r,
  input wire             main_domain_up_r,
  input wire             busy_r
);
  // One clock domain, reset disables every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Read data only moves after a read strobe
  property p_rdata_hold;
    !$past(reg_rd) |-> $stable(reg_rdata_r);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_unmapped;
    reg_rd && reg_addr == 8'h85 |=> reg_rdata_r == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Timer start request is a single-cycle pulse, only in timer mode
  property p_wait_pulse;
    wait_timer_start_r |=> !wait_timer_start_r;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("timer start too long");
  property p_wait_mode;
    wait_timer_start_r |-> wait_mode;
  endproperty
  a_wait_mode: assert property (p_wait_mode) else $error("timer start in pause mode");
  property p_no_dir;
    wait_dir == 2'h0 && $past(wait_dir) == 2'h0 |-> !wait_timer_start_r;
  endproperty
  a_no_dir: assert property (p_no_dir) else $error("wait with direction off");
  // Slot actions only happen while the sequencer runs
  property p_act_busy;
    $changed({linreg_en_r, switcher_en_r, gen_out_r, pulldown_off_r, out_clk_en_r,
      cal_clk_en_r}) |-> busy_r;
  endproperty
  a_act_busy: assert property (p_act_busy) else $error("output changed while idle");
  property p_domains;
    main_domain_up_r |-> system_domain_up_r;
  endproperty
  a_domains: assert property (p_domains) else $error("main up without system up");
  // Walk length counter; sixteen slots of the longest code bound any walk without a wait
  reg [31:0] busy_cnt_r;
  always @(posedge mclk) begin
    if (!rst_n || !busy_r) begin
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
    end
  end
  property p_busy_bound;
    busy_r |-> busy_cnt_r <= 32'h0000_1000 * TICK_CYCLES + 32'h0000_0030;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("walk did not finish");

  // Main scenarios reached
  c_wait: cover property (wait_timer_start_r);
  c_walk: cover property ($rose(busy_r));
  c_out: cover property ($fell(gen_out_r[0]));
endmodule

bind psq_sequencer psq_sequencer_properties #(.TICK_CYCLES(TICK_CYCLES), .N_LIN(N_LIN),
  .N_SW(N_SW), .N_OUT(N_OUT)) psq_sequencer_properties_inst (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .wait_dir(wait_dir),
  .wait_mode(wait_mode), .wait_timer_start_r(wait_timer_start_r),
  .linreg_en_r(linreg_en_r), .switcher_en_r(switcher_en_r), .gen_out_r(gen_out_r),
  .pulldown_off_r(pulldown_off_r), .out_clk_en_r(out_clk_en_r),
  .cal_clk_en_r(cal_clk_en_r), .system_domain_up_r(system_domain_up_r),
  .main_domain_up_r(main_domain_up_r), .busy_r(busy_r));

// *** bench/psq_sequencer_test.sv ***
// Self-checking bench for the slot sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count = cmp_count + 1; if ((got) !== (ex)) begin \
  failures = failures + 1; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module psq_sequencer_test;
  reg  [7:0]  reg_addr, reg_wdata;
  reg  [1:0]  wait_dir;
  reg         mclk, rst_n, reg_wr, reg_rd, power_up_req, power_down_req, standby_req;
  reg         wait_mode, ext_pause_input, wait_timer_done;
  wire [7:0]  reg_rdata_r;
  wire [3:0]  linreg_en_r, switcher_en_r;
  wire [4:0]  gen_out_r;
  wire        wait_timer_start_r, pulldown_off_r, out_clk_en_r, cal_clk_en_r;
  wire        system_domain_up_r, main_domain_up_r, busy_r;
  wire [17:0] outs;
  integer     failures, cmp_count, cycles, i, busy_n;
  localparam  TICK = 4;
  localparam [119:0] OFS = {8'h81, 8'h82, 8'h83, 8'h84, 8'h88, 8'h89, 8'h8A, 8'h8D,
    8'h8E, 8'h8F, 8'h90, 8'h91, 8'h92, 8'h95, 8'h96};

  // All slot-driven outputs in one word for comparison
  assign outs = {linreg_en_r, switcher_en_r, gen_out_r, pulldown_off_r, out_clk_en_r,
    cal_clk_en_r, system_domain_up_r, main_domain_up_r};

  psq_sequencer #(.TICK_CYCLES(TICK)) psq_sequencer_inst (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .power_up_req(power_up_req),
    .power_down_req(power_down_req), .standby_req(standby_req), .wait_dir(wait_dir),
    .wait_mode(wait_mode), .ext_pause_input(ext_pause_input),
    .wait_timer_done(wait_timer_done), .wait_timer_start_r(wait_timer_start_r),
    .linreg_en_r(linreg_en_r), .switcher_en_r(switcher_en_r), .gen_out_r(gen_out_r),
    .pulldown_off_r(pulldown_off_r), .out_clk_en_r(out_clk_en_r),
    .cal_clk_en_r(cal_clk_en_r), .system_domain_up_r(system_domain_up_r),
    .main_domain_up_r(main_domain_up_r), .busy_r(busy_r));

  // Verdict and end of run
  task report_and_stop;
    begin
      if (failures == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  // Slot duration in 32 us units for a timing code
  function integer dur_units(input [3:0] c);
    begin
      case (c)
        4'h9:    dur_units = 12;
        4'hA:    dur_units = 14;
        4'hB:    dur_units = 16;
        4'hC:    dur_units = 32;
        4'hD:    dur_units = 64;
        4'hE:    dur_units = 128;
        4'hF:    dur_units = 256;
        default: dur_units = c + 1;
      endcase
    end
  endfunction

  // Byte register write and read-compare
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] ex);
    begin
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      `CHK("register", ex, reg_rdata_r)
    end
  endtask

  // One-cycle request pulse: bit 0 up, bit 1 down, bit 2 standby
  task req(input [2:0] k);
    begin
      @(negedge mclk);
      {standby_req, power_down_req, power_up_req} = k;
      @(negedge mclk);
      {standby_req, power_down_req, power_up_req} = 3'h0;
    end
  endtask

  // Wait for the walk to finish, counting busy cycles
  task settle;
    begin
      busy_n = 0;
      @(negedge mclk);
      while (busy_r === 1'b1 && busy_n < 3000) begin
        busy_n = busy_n + 1;
        @(negedge mclk);
      end
    end
  endtask

  // Clock generation
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      report_and_stop;
    end
  end

  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, power_up_req, power_down_req, standby_req} = 6'h00;
    {wait_mode, ext_pause_input, wait_timer_done, wait_dir} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    // Reset values, storage, read-only position nibble, unmapped place
    for (i = 0; i < 15; i = i + 1) rd(OFS[i*8 +: 8], 8'h00);
    for (i = 0; i < 15; i = i + 1) wr(OFS[i*8 +: 8], 8'h11 * (15 - i));
    for (i = 0; i < 15; i = i + 1) rd(OFS[i*8 +: 8], i == 14 ? 8'h10 : 8'h11 * (15 - i));
    wr(8'h85, 8'h77);
    rd(8'h85, 8'h00);
    // Slot plan: lin1@1 lin2@2 lin4@6, sw1@4 sw2@3 sw4@4, out0 2..5, slot 5 empty
    wr(8'h81, 8'hA0);
    wr(8'h82, 8'h91);
    wr(8'h83, 8'h21);
    wr(8'h84, 8'h60);
    wr(8'h88, 8'h30);
    wr(8'h89, 8'h34);
    wr(8'h8A, 8'h04);
    wr(8'h8D, 8'h52);
    for (i = 0; i < 4; i = i + 1) wr(8'h8E + i, 8'h00);
    wr(8'h92, 8'h42);
    wr(8'h95, 8'h43);
    wr(8'h96, 8'h26);
    // Power-up to the top slot, wait step disabled by direction
    req(3'h1);
    settle;
    `CHK("up busy", 106, busy_n)
    `CHK("up outputs", 18'h2EC1F, outs)
    rd(8'h81, 8'hA6);
    // Standby walk down stops at its slot, long empty dwell
    wr(8'h82, 8'hC0);
    req(3'h4);
    settle;
    `CHK("standby busy", 152, busy_n)
    `CHK("standby outputs", 18'h0C020, outs)
    rd(8'h81, 8'hA2);
    // Power-down with timer wait at slot 2
    wait_dir = 2'h2;
    wait_mode = 1'b1;
    req(3'h2);
    busy_n = 0;
    while (wait_timer_start_r !== 1'b1 && busy_n < 300) begin
      @(negedge mclk);
      busy_n = busy_n + 1;
    end
    `CHK("timer start", 1'b1, wait_timer_start_r)
    repeat (20) @(negedge mclk);
    `CHK("held busy", 1'b1, busy_r)
    `CHK("held outputs", 18'h04000, outs)
    wait_timer_done = 1'b1;
    @(negedge mclk);
    wait_timer_done = 1'b0;
    settle;
    `CHK("down outputs", 18'h00000, outs)
    rd(8'h81, 8'hA0);
    // Power-up with pause-input wait; a request while busy is ignored
    wait_dir = 2'h1;
    wait_mode = 1'b0;
    req(3'h1);
    repeat (60) @(negedge mclk);
    `CHK("paused busy", 1'b1, busy_r)
    `CHK("paused outputs", 18'h0C020, outs)
    req(3'h2);
    ext_pause_input = 1'b1;
    settle;
    `CHK("resumed outputs", 18'h2EC1F, outs)
    rd(8'h81, 8'hA6);
    // Full power-down, then every slot-length code on a one-slot walk up and down
    req(3'h2);
    settle;
    `CHK("off outputs", 18'h00000, outs)
    wr(8'h95, 8'h11);
    wr(8'h96, 8'h11);
    for (i = 0; i < 16; i = i + 1) begin
      wr(8'h82, i[7:0]);
      req(3'h1);
      settle;
      `CHK("up slot time", TICK * dur_units(i[3:0]) + 3, busy_n)
      req(3'h2);
      settle;
      `CHK("down slot time", TICK * dur_units(i[3:0]) + 3, busy_n)
    end
    report_and_stop;
  end
endmodule
